// file: logic/ptu_regs.vh
// Register offsets, field positions, reset values and mode codes of the PWM timer unit.
// Assumes a byte-addressed register port with an eight-bit address.
`ifndef PTU_REGS_VH
`define PTU_REGS_VH

// Register port widths
`define PTU_ADDR_W              8
`define PTU_DATA_W              16

// Register byte offsets
`define PTU_OFF_CTL_ZERO        8'h00
`define PTU_OFF_CTL_ONE         8'h04
`define PTU_OFF_PIN_CTRL        8'h08
`define PTU_OFF_CAPT_EDGE       8'h0C
`define PTU_OFF_TRIG_EDGE       8'h10
`define PTU_OFF_OPTION          8'h14
`define PTU_OFF_CNT_READ        8'h18
`define PTU_OFF_PERIOD          8'h1C
`define PTU_OFF_DUTY_ONE        8'h20
`define PTU_OFF_DUTY_TWO        8'h24
`define PTU_OFF_DUTY_THREE      8'h28
`define PTU_OFF_STATUS          8'h2C
`define PTU_OFF_PERIOD_BUF      8'h30
`define PTU_OFF_DUTY_BUF_ONE    8'h34
`define PTU_OFF_DUTY_BUF_TWO    8'h38
`define PTU_OFF_DUTY_BUF_THREE  8'h3C

// Field positions
`define PTU_CE_BIT              7
`define PTU_CKS_MSB             2
`define PTU_CKS_LSB             0
`define PTU_MD_MSB              2
`define PTU_MD_LSB              0
`define PTU_ST_RUN_BIT          0
`define PTU_ST_ARM_BIT          1
`define PTU_ST_TOG_BIT          2

// Operating mode codes
`define PTU_MODE_PWM            3'h4

// Reset values and the counter clear value
`define PTU_RST_BYTE            8'h00
`define PTU_RST_WORD            16'h0000
`define PTU_CNT_TOP             16'hFFFF
`define PTU_CNT_ZERO            16'h0000

`endif

// file: logic/ptu_prescaler.v
// Count clock divider of the PWM timer unit: one-cycle enable pulse.
// Assumes clk_sys_i is the only clock; select codes 0 to 6 divide by two to the power of the code, code 7 never ticks.
`timescale 1ns/1ns
`default_nettype none

module ptu_prescaler (
    // Clock and reset
    input  wire        clk_sys_i,
    input  wire        rst_i,
    // Control
    input  wire        run_i,
    input  wire [2:0]  clk_sel_i,
    // Count clock enable
    output reg         tick_o
);

    reg  [6:0] div_ff;
    wire [6:0] nxt_div;
    wire [7:0] span;

    // Terminal count for the chosen division
    assign span    = 8'h01 << clk_sel_i;
    assign nxt_div = div_ff + 7'h01;

    // Divider restarts with counting so the first period is whole
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            div_ff <= 7'h00;
            tick_o <= 1'b0;
        end else if (!run_i) begin
            div_ff <= 7'h00;
            tick_o <= 1'b0;
        end else if ({1'b0, nxt_div} >= span) begin
            div_ff <= 7'h00;
            tick_o <= 1'b1;
        end else begin
            div_ff <= nxt_div;
            tick_o <= 1'b0;
        end
    end

endmodule // ptu_prescaler

`default_nettype wire

// file: logic/ptu_duty_chan.v
// One duty channel: working buffer, compare against the counter and active state.
// Assumes the caller gives the counter's next value together with the count tick.
`timescale 1ns/1ns
`default_nettype none

module ptu_duty_chan (
    // Clock and reset
    input  wire        clk_sys_i,
    input  wire        rst_i,
    // Counter events
    input  wire        run_i,
    input  wire        tick_i,
    input  wire        clear_i,
    input  wire        load_i,
    input  wire [15:0] cnt_next_i,
    // Compare value
    input  wire [15:0] cmp_val_i,
    // Results
    output reg  [15:0] buf_o,
    output reg         active_o,
    output reg         match_o
);

    wire [15:0] nxt_buf;

    // Buffer takes the register only on a load
    assign nxt_buf = load_i ? cmp_val_i : buf_o;

    // Active from clear until the counter reaches the buffered width
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            buf_o    <= 16'h0000;
            active_o <= 1'b0;
            match_o  <= 1'b0;
        end else begin
            buf_o <= nxt_buf;
            if (!run_i) begin
                active_o <= 1'b0;
                match_o  <= 1'b0;
            end else if (tick_i) begin
                match_o <= (cnt_next_i == nxt_buf);
                if (clear_i)
                    active_o <= (nxt_buf != 16'h0000);
                else if (cnt_next_i == nxt_buf)
                    active_o <= 1'b0;
            end else begin
                match_o <= 1'b0;
            end
        end
    end

endmodule // ptu_duty_chan

`default_nettype wire

// file: logic/ptu_pwm_timer_unit.v
// PWM timer unit: 16-bit counter, period and three duty channels, register port.
// Assumes a single 100 MHz clock and a master that never issues read and write together.
//
// Summary of operation
// - PWM operation only when the three-bit mode field holds 100.
// - Count enable rolls counter FFFF to 0000, counts up, drives outputs 1-3.
// - Output k active width equals channel k compare value count clocks.
// - Period equals period compare value plus one count clocks.
// - Pin 0 toggles once per PWM period.
// - Compare values written while counting apply only at counter clear.
// - Period interrupt pulses at the clear that follows the period match.
// - Channel k interrupt pulses when counter equals channel k buffer.
// - Past the first clear after enabling, buffers reload only after the channel 1 register was written.
// - After that write, all buffers reload at the next clear.
// - Level bit 0 makes active high, 1 low; pins driven when enabled.
// - Disabled pin 0 holds its level bit value.
// - Counter readback register returns live counter.
// - Capture edge and option registers do not affect PWM operation.
// - Compare value zero keeps output inactive.
// - Compare value equal to period plus one keeps output active.
`timescale 1ns/1ns
`default_nettype none
`include "ptu_regs.vh"

module ptu_pwm_timer_unit (
    // Clock and reset
    input  wire        clk_sys_i,
    input  wire        rst_i,
    // Register port
    input  wire [7:0]  reg_addr_i,
    input  wire [15:0] reg_wdata_i,
    input  wire        reg_wr_i,
    input  wire        reg_rd_i,
    output reg  [15:0] reg_rdata_o,
    // Output pins
    output reg         toggle_output_pin_o,
    output reg  [2:0]  pwm_output_pin_o,
    output reg  [2:0]  pwm_output_pin_oe_o,
    // Compare events
    output reg         period_match_irq_o,
    output reg  [2:0]  duty_match_irq_o
);

    // Software registers
    reg  [7:0]  ctl_zero_ff;
    reg  [7:0]  ctl_one_ff;
    reg  [7:0]  pin_ctrl_ff;
    reg  [7:0]  capt_edge_ff;
    reg  [7:0]  trig_edge_ff;
    reg  [7:0]  option_ff;
    reg  [15:0] period_cmp_ff;
    reg  [15:0] duty_cmp_one_ff;
    reg  [15:0] duty_cmp_two_ff;
    reg  [15:0] duty_cmp_three_ff;

    // Counter state
    reg  [15:0] cnt_ff;
    reg  [15:0] period_buf_ff;
    reg         first_ff;
    reg         arm_ff;
    reg         toggle_ff;

    // Combinational control
    wire        run;
    wire        tick;
    wire        at_period;
    wire        clear_ev;
    wire        load;
    wire        load_any;
    wire [15:0] nxt_cnt;
    wire        wr_duty_one;

    // Channel results
    wire [15:0] duty_buf_one;
    wire [15:0] duty_buf_two;
    wire [15:0] duty_buf_three;
    wire [2:0]  chan_active;
    wire [2:0]  chan_match;

    // Read path
    reg  [15:0] nxt_rdata;

    // Decode of a write to one register offset
    function wr_hit;
        input [7:0] addr;
        input [7:0] off;
        input       wr;
        begin
            wr_hit = wr && (addr == off);
        end
    endfunction

    // Counter increment kept in one place
    function [15:0] cnt_inc;
        input [15:0] val;
        begin
            cnt_inc = val + 16'h0001;
        end
    endfunction

    // Counting runs only with enable set in PWM mode; capture edge and option stay unread
    assign run = ctl_zero_ff[`PTU_CE_BIT] &&
                 (ctl_one_ff[`PTU_MD_MSB:`PTU_MD_LSB] == `PTU_MODE_PWM);

    // Clear on period match, or on the roll out of FFFF after enabling
    assign at_period = (cnt_ff == period_buf_ff);
    assign clear_ev  = tick && (first_ff || at_period);
    assign nxt_cnt   = clear_ev ? `PTU_CNT_ZERO : cnt_inc(cnt_ff);

    // Reload at the first clear after enabling or at a clear when armed; when stopped, buffers track registers
    assign load        = clear_ev && (first_ff || arm_ff);
    assign load_any    = load || !run;
    assign wr_duty_one = wr_hit(reg_addr_i, `PTU_OFF_DUTY_ONE, reg_wr_i);

    // Count clock divider
    ptu_prescaler u_prescaler (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .run_i     (run),
        .clk_sel_i (ctl_zero_ff[`PTU_CKS_MSB:`PTU_CKS_LSB]),
        .tick_o    (tick)
    );

    // Duty channel one
    ptu_duty_chan u_chan_one (
        .clk_sys_i  (clk_sys_i),
        .rst_i      (rst_i),
        .run_i      (run),
        .tick_i     (tick),
        .clear_i    (clear_ev),
        .load_i     (load_any),
        .cnt_next_i (nxt_cnt),
        .cmp_val_i  (duty_cmp_one_ff),
        .buf_o      (duty_buf_one),
        .active_o   (chan_active[0]),
        .match_o    (chan_match[0])
    );

    // Duty channel two
    ptu_duty_chan u_chan_two (
        .clk_sys_i  (clk_sys_i),
        .rst_i      (rst_i),
        .run_i      (run),
        .tick_i     (tick),
        .clear_i    (clear_ev),
        .load_i     (load_any),
        .cnt_next_i (nxt_cnt),
        .cmp_val_i  (duty_cmp_two_ff),
        .buf_o      (duty_buf_two),
        .active_o   (chan_active[1]),
        .match_o    (chan_match[1])
    );

    // Duty channel three
    ptu_duty_chan u_chan_three (
        .clk_sys_i  (clk_sys_i),
        .rst_i      (rst_i),
        .run_i      (run),
        .tick_i     (tick),
        .clear_i    (clear_ev),
        .load_i     (load_any),
        .cnt_next_i (nxt_cnt),
        .cmp_val_i  (duty_cmp_three_ff),
        .buf_o      (duty_buf_three),
        .active_o   (chan_active[2]),
        .match_o    (chan_match[2])
    );

    // Register writes; compare registers accept writes at any time
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            ctl_zero_ff       <= `PTU_RST_BYTE;
            ctl_one_ff        <= `PTU_RST_BYTE;
            pin_ctrl_ff       <= `PTU_RST_BYTE;
            capt_edge_ff      <= `PTU_RST_BYTE;
            trig_edge_ff      <= `PTU_RST_BYTE;
            option_ff         <= `PTU_RST_BYTE;
            period_cmp_ff     <= `PTU_RST_WORD;
            duty_cmp_one_ff   <= `PTU_RST_WORD;
            duty_cmp_two_ff   <= `PTU_RST_WORD;
            duty_cmp_three_ff <= `PTU_RST_WORD;
        end else begin
            if (wr_hit(reg_addr_i, `PTU_OFF_CTL_ZERO, reg_wr_i))
                ctl_zero_ff <= reg_wdata_i[7:0];
            if (wr_hit(reg_addr_i, `PTU_OFF_CTL_ONE, reg_wr_i))
                ctl_one_ff <= reg_wdata_i[7:0];
            if (wr_hit(reg_addr_i, `PTU_OFF_PIN_CTRL, reg_wr_i))
                pin_ctrl_ff <= reg_wdata_i[7:0];
            if (wr_hit(reg_addr_i, `PTU_OFF_CAPT_EDGE, reg_wr_i))
                capt_edge_ff <= reg_wdata_i[7:0];
            if (wr_hit(reg_addr_i, `PTU_OFF_TRIG_EDGE, reg_wr_i))
                trig_edge_ff <= reg_wdata_i[7:0];
            if (wr_hit(reg_addr_i, `PTU_OFF_OPTION, reg_wr_i))
                option_ff <= reg_wdata_i[7:0];
            if (wr_hit(reg_addr_i, `PTU_OFF_PERIOD, reg_wr_i))
                period_cmp_ff <= reg_wdata_i;
            if (wr_duty_one)
                duty_cmp_one_ff <= reg_wdata_i;
            if (wr_hit(reg_addr_i, `PTU_OFF_DUTY_TWO, reg_wr_i))
                duty_cmp_two_ff <= reg_wdata_i;
            if (wr_hit(reg_addr_i, `PTU_OFF_DUTY_THREE, reg_wr_i))
                duty_cmp_three_ff <= reg_wdata_i;
        end
    end

    // Update arm: a channel 1 write sets it and wins over the clear by a load
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i)
            arm_ff <= 1'b0;
        else if (wr_duty_one)
            arm_ff <= 1'b1;
        else if (load_any)
            arm_ff <= 1'b0;
    end

    // Counter and period buffer; stopped counter parks at FFFF
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_ff        <= `PTU_CNT_TOP;
            period_buf_ff <= `PTU_RST_WORD;
            first_ff      <= 1'b1;
        end else if (!run) begin
            cnt_ff        <= `PTU_CNT_TOP;
            period_buf_ff <= period_cmp_ff;
            first_ff      <= 1'b1;
        end else if (tick) begin
            cnt_ff   <= nxt_cnt;
            first_ff <= 1'b0;
            if (load)
                period_buf_ff <= period_cmp_ff;
        end
    end

    // Pin 0 square wave flips at every period clear except the start
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i)
            toggle_ff <= 1'b0;
        else if (!run)
            toggle_ff <= 1'b0;
        else if (clear_ev && !first_ff)
            toggle_ff <= ~toggle_ff;
    end

    // Period event: one system cycle at the clear after the match
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i)
            period_match_irq_o <= 1'b0;
        else
            period_match_irq_o <= run && clear_ev && !first_ff;
    end

    // Duty events passed on from the channels
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i)
            duty_match_irq_o <= 3'h0;
        else
            duty_match_irq_o <= chan_match;
    end

    // Pin drive; one cycle behind the channel state so every pin is a flop
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            pwm_output_pin_o    <= 3'h0;
            pwm_output_pin_oe_o <= 3'h0;
            toggle_output_pin_o <= 1'b0;
        end else begin
            pwm_output_pin_oe_o <= {pin_ctrl_ff[6], pin_ctrl_ff[4], pin_ctrl_ff[2]};
            pwm_output_pin_o[0] <= pin_ctrl_ff[2] & (chan_active[0] ^ pin_ctrl_ff[3]);
            pwm_output_pin_o[1] <= pin_ctrl_ff[4] & (chan_active[1] ^ pin_ctrl_ff[5]);
            pwm_output_pin_o[2] <= pin_ctrl_ff[6] & (chan_active[2] ^ pin_ctrl_ff[7]);
            if (pin_ctrl_ff[0])
                toggle_output_pin_o <= toggle_ff;
            else
                toggle_output_pin_o <= pin_ctrl_ff[1];
        end
    end

    // Read decode; unmapped offsets read zero
    always @* begin
        nxt_rdata = 16'h0000;
        case (reg_addr_i)
            `PTU_OFF_CTL_ZERO:       nxt_rdata = {8'h00, ctl_zero_ff};
            `PTU_OFF_CTL_ONE:        nxt_rdata = {8'h00, ctl_one_ff};
            `PTU_OFF_PIN_CTRL:       nxt_rdata = {8'h00, pin_ctrl_ff};
            `PTU_OFF_CAPT_EDGE:      nxt_rdata = {8'h00, capt_edge_ff};
            `PTU_OFF_TRIG_EDGE:      nxt_rdata = {8'h00, trig_edge_ff};
            `PTU_OFF_OPTION:         nxt_rdata = {8'h00, option_ff};
            `PTU_OFF_CNT_READ:       nxt_rdata = cnt_ff;
            `PTU_OFF_PERIOD:         nxt_rdata = period_cmp_ff;
            `PTU_OFF_DUTY_ONE:       nxt_rdata = duty_cmp_one_ff;
            `PTU_OFF_DUTY_TWO:       nxt_rdata = duty_cmp_two_ff;
            `PTU_OFF_DUTY_THREE:     nxt_rdata = duty_cmp_three_ff;
            `PTU_OFF_STATUS:         nxt_rdata = {13'h0000, toggle_ff, arm_ff, run};
            `PTU_OFF_PERIOD_BUF:     nxt_rdata = period_buf_ff;
            `PTU_OFF_DUTY_BUF_ONE:   nxt_rdata = duty_buf_one;
            `PTU_OFF_DUTY_BUF_TWO:   nxt_rdata = duty_buf_two;
            `PTU_OFF_DUTY_BUF_THREE: nxt_rdata = duty_buf_three;
            default:                 nxt_rdata = 16'h0000;
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i)
            reg_rdata_o <= 16'h0000;
        else if (reg_rd_i)
            reg_rdata_o <= nxt_rdata;
        else
            reg_rdata_o <= 16'h0000;
    end

endmodule // ptu_pwm_timer_unit

`default_nettype wire

// file: testbench/ptu_pwm_timer_unit_assertions.sv
// Checker of the PWM timer unit port behaviour.
// Assumes binding to ptu_pwm_timer_unit; sees its ports only.
`timescale 1ns/1ns
`default_nettype none
module ptu_pwm_timer_unit_assertions (
    // Clock and reset
    input wire logic        clk_sys_i,
    input wire logic        rst_i,
    // Register port
    input wire logic [7:0]  reg_addr_i,
    input wire logic        reg_wr_i,
    input wire logic        reg_rd_i,
    input wire logic [15:0] reg_rdata_o,
    // Pins and events
    input wire logic        toggle_output_pin_o,
    input wire logic [2:0]  pwm_output_pin_o,
    input wire logic [2:0]  pwm_output_pin_oe_o,
    input wire logic        period_match_irq_o,
    input wire logic [2:0]  duty_match_irq_o
);
    logic [3:0] wr_age_ff;
    logic       wrote_ff;

    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    // Write history; a start may move pins up to eleven cycles after its write
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            wr_age_ff <= 4'hF;
            wrote_ff  <= 1'b0;
        end else begin
            wr_age_ff <= reg_wr_i ? 4'h0 : ((wr_age_ff == 4'hF) ? 4'hF : wr_age_ff + 4'h1);
            wrote_ff  <= wrote_ff | reg_wr_i;
        end
    end

    rd_idle_zero_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 16'h0000)
        else $error("read data not zero outside a read");
    rd_unmapped_a: assert property (reg_rd_i && (reg_addr_i > 8'h3C ||
        reg_addr_i[1:0] != 2'b00) |=> reg_rdata_o == 16'h0000)
        else $error("unmapped read not zero");
    count_idle_a: assert property (reg_rd_i && reg_addr_i == 8'h18 && !wrote_ff
        |=> reg_rdata_o == 16'hFFFF)
        else $error("idle counter not at top");
    pin_off_low_a: assert property ((pwm_output_pin_o & ~pwm_output_pin_oe_o) == 3'b000)
        else $error("disabled pin driven high");
    oe_by_write_a: assert property ($changed(pwm_output_pin_oe_o) |-> wr_age_ff <= 4'h2)
        else $error("enable moved without a write");
    toggle_cause_a: assert property ($changed(toggle_output_pin_o) |-> period_match_irq_o
        || $past(period_match_irq_o) || wr_age_ff <= 4'h2)
        else $error("pin 0 moved away from a clear");
    pwm_cause_a: assert property ($changed(pwm_output_pin_o) |-> period_match_irq_o
        || duty_match_irq_o != 3'b000 || $past(period_match_irq_o)
        || $past(duty_match_irq_o) != 3'b000 || wr_age_ff <= 4'hB)
        else $error("pwm pin moved without a match");
    quiet_start_a: assert property (!wrote_ff |-> !period_match_irq_o
        && duty_match_irq_o == 3'b000)
        else $error("event before any setup");
endmodule // ptu_pwm_timer_unit_assertions
`default_nettype wire

// file: testbench/ptu_pwm_timer_unit_tb_top.sv
// Self-checking bench of the PWM timer unit: table of waveforms, then hand cases.
// Assumes the register map header and a 100 MHz system clock.
`timescale 1ns/1ns
`default_nettype none
`include "ptu_regs.vh"
module ptu_pwm_timer_unit_tb_top;
    logic        clk_sys_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [7:0]  reg_addr_i = 8'h00;
    logic [15:0] reg_wdata_i = 16'h0000;
    logic        reg_wr_i = 1'b0;
    logic        reg_rd_i = 1'b0;
    logic [15:0] reg_rdata_o;
    logic        toggle_output_pin_o;
    logic        period_match_irq_o;
    logic [2:0]  pwm_output_pin_o;
    logic [2:0]  pwm_output_pin_oe_o;
    logic [2:0]  duty_match_irq_o;
    int          num_errors = 0;
    int          checked = 0;
    int          cycles = 0;
    // Rows: period, duty 1..3, pin control, clock select
    logic [15:0] tbl [0:2][0:5] = '{
        '{16'h0004, 16'h0001, 16'h0002, 16'h0003, 16'h0055, 16'h0000},
        '{16'h0002, 16'h0003, 16'h0001, 16'h0000, 16'h0046, 16'h0001},
        '{16'h0004, 16'h0000, 16'h0005, 16'h0004, 16'h00FD, 16'h0002}};
    logic [7:0]  ofs [0:4] = '{`PTU_OFF_PERIOD, `PTU_OFF_DUTY_ONE, `PTU_OFF_DUTY_TWO,
        `PTU_OFF_DUTY_THREE, `PTU_OFF_PIN_CTRL};
    logic [15:0] v1, v2, cw;
    logic        tp;
    int          hi [0:2];
    int          ir [0:2];
    int          np, nt, w, act, i, j, k;

    ptu_pwm_timer_unit u_dut (.clk_sys_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
        .reg_rd_i, .reg_rdata_o, .toggle_output_pin_o, .pwm_output_pin_o,
        .pwm_output_pin_oe_o, .period_match_irq_o, .duty_match_irq_o);

    // Free-running 100 MHz clock
    initial forever #5 clk_sys_i = ~clk_sys_i;

    // Hang guard, well above the few hundred cycles the run needs
    always @(posedge clk_sys_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors = num_errors + 1;
            give_verdict();
        end
    end

    task automatic give_verdict();
        if (num_errors == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Bus cycles: strobes last one cycle, read data stand in the next
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [15:0] e);
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
        #1 chk(reg_rdata_o, e);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask

    initial begin
        cyc(2);
        rst_i <= 1'b0;
        rdc(`PTU_OFF_CNT_READ, `PTU_CNT_TOP);
        rdc(8'h40, 16'h0000);
        wr(`PTU_OFF_CAPT_EDGE, 16'hFFFF);
        wr(`PTU_OFF_OPTION, 16'hFFFF);
        rdc(`PTU_OFF_CAPT_EDGE, 16'h00FF);
        wr(`PTU_OFF_CTL_ONE, {13'h0000, `PTU_MODE_PWM});
        // Each row: stop, program, start, then count four whole periods
        for (i = 0; i < 3; i++) begin
            cw = tbl[i][4];
            wr(`PTU_OFF_CTL_ZERO, 16'h0000);
            for (j = 0; j < 5; j++) wr(ofs[j], tbl[i][j]);
            wr(`PTU_OFF_CTL_ZERO, 16'h0080 | tbl[i][5]);
            cyc(20);
            w = (4 * (tbl[i][0] + 1)) << tbl[i][5];
            np = 0;
            nt = 0;
            hi = '{0, 0, 0};
            ir = '{0, 0, 0};
            #1 tp = toggle_output_pin_o;
            repeat (w) begin
                @(posedge clk_sys_i);
                #1 np += period_match_irq_o;
                nt += (toggle_output_pin_o !== tp);
                tp = toggle_output_pin_o;
                for (k = 0; k < 3; k++) hi[k] += pwm_output_pin_o[k];
                for (k = 0; k < 3; k++) ir[k] += duty_match_irq_o[k];
            end
            chk(16'(np), 16'h0004);
            chk(16'(nt), cw[0] ? 16'h0004 : 16'h0000);
            if (!cw[0]) chk({15'h0000, tp}, {15'h0000, cw[1]});
            chk({13'h0000, pwm_output_pin_oe_o}, {13'h0000, cw[6], cw[4], cw[2]});
            for (k = 0; k < 3; k++) begin
                act = (4 * tbl[i][k + 1]) << tbl[i][5];
                act = cw[2 * k + 2] ? (cw[2 * k + 3] ? w - act : act) : 0;
                chk(16'(hi[k]), 16'(act));
                chk(16'(ir[k]), (tbl[i][k + 1] <= tbl[i][0]) ? 16'h0004 : 16'h0000);
            end
        end
        // Stop with the three PWM level bits set: pins rest at their inactive level
        wr(`PTU_OFF_CTL_ZERO, 16'h0000);
        cyc(5);
        #1 chk({13'h0000, pwm_output_pin_o}, 16'h0007);
        chk({15'h0000, toggle_output_pin_o}, 16'h0000);
        rdc(`PTU_OFF_CNT_READ, `PTU_CNT_TOP);
        // A mode other than PWM must not count
        wr(`PTU_OFF_CTL_ONE, 16'h0005);
        wr(`PTU_OFF_CTL_ZERO, 16'h0080);
        cyc(20);
        rdc(`PTU_OFF_CNT_READ, `PTU_CNT_TOP);
        wr(`PTU_OFF_CTL_ZERO, 16'h0000);
        wr(`PTU_OFF_CTL_ONE, {13'h0000, `PTU_MODE_PWM});
        wr(`PTU_OFF_DUTY_ONE, 16'h0001);
        wr(`PTU_OFF_DUTY_TWO, 16'h0002);
        wr(`PTU_OFF_CTL_ZERO, 16'h0080);
        cyc(20);
        // Running changes wait for a duty one write, then land at a clear
        wr(`PTU_OFF_PERIOD, 16'h0009);
        wr(`PTU_OFF_DUTY_TWO, 16'h0007);
        cyc(30);
        rdc(`PTU_OFF_PERIOD_BUF, 16'h0004);
        rdc(`PTU_OFF_DUTY_BUF_TWO, 16'h0002);
        wr(`PTU_OFF_DUTY_ONE, 16'h0001);
        cyc(25);
        rdc(`PTU_OFF_PERIOD_BUF, 16'h0009);
        rdc(`PTU_OFF_DUTY_BUF_TWO, 16'h0007);
        wr(`PTU_OFF_DUTY_ONE, 16'h0003);
        cyc(25);
        rdc(`PTU_OFF_DUTY_BUF_ONE, 16'h0003);
        // Back-to-back counter reads see the live count
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= `PTU_OFF_CNT_READ;
        @(posedge clk_sys_i);
        #1 v1 = reg_rdata_o;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
        #1 v2 = reg_rdata_o;
        chk(v2, (v1 == 16'h0009) ? 16'h0000 : v1 + 16'h0001);
        // Reset in mid-run returns the unit to idle
        @(posedge clk_sys_i);
        rst_i <= 1'b1;
        cyc(2);
        #1 chk({12'h000, pwm_output_pin_o, period_match_irq_o}, 16'h0000);
        chk({9'h000, pwm_output_pin_oe_o, duty_match_irq_o, toggle_output_pin_o}, 16'h0000);
        @(posedge clk_sys_i);
        rst_i <= 1'b0;
        rdc(`PTU_OFF_CNT_READ, `PTU_CNT_TOP);
        give_verdict();
    end
endmodule // ptu_pwm_timer_unit_tb_top

bind ptu_pwm_timer_unit ptu_pwm_timer_unit_assertions u_chk (.clk_sys_i, .rst_i,
    .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .toggle_output_pin_o,
    .pwm_output_pin_o, .pwm_output_pin_oe_o, .period_match_irq_o, .duty_match_irq_o);
`default_nettype wire
